// ==== core/rtcgs_pkg.sv ====
// package: register map, field positions and constants of the calendar clock gate and selector
package rtcgs_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] RTCGS_ADDR_PCE0    = 8'h00;
  localparam logic [7:0] RTCGS_ADDR_SEL     = 8'h04;
  localparam logic [7:0] RTCGS_ADDR_SUPMODE = 8'h08;
  localparam logic [7:0] RTCGS_ADDR_CTRL    = 8'h0C;
  localparam logic [7:0] RTCGS_ADDR_SECCNT  = 8'h10;
  localparam logic [7:0] RTCGS_ADDR_FIXCNT  = 8'h14;
  localparam logic [7:0] RTCGS_ADDR_IRQ_ST  = 8'h18;
  localparam logic [7:0] RTCGS_ADDR_IRQ_MSK = 8'h1C;
  localparam logic [7:0] RTCGS_ADDR_STATUS  = 8'h20;

  localparam logic [7:0] RTCGS_RST_BYTE     = 8'h00;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int RTCGS_GATE_BIT      = 7;
  localparam int RTCGS_MAIN_SRC_BIT  = 7;
  localparam int RTCGS_DIV_HI_BIT    = 6;
  localparam int RTCGS_DIV_LO_BIT    = 5;
  localparam int RTCGS_SRC_HI_BIT    = 2;
  localparam int RTCGS_SRC_LO_BIT    = 1;
  localparam int RTCGS_LS_EN_BIT     = 4;
  localparam int RTCGS_LPC_BIT       = 7;
  localparam int RTCGS_RUN_BIT       = 7;
  localparam int RTCGS_IRQ_SEC_BIT   = 0;
  localparam int RTCGS_IRQ_FIX_BIT   = 1;

  localparam logic [7:0] RTCGS_SEL_MASK  = 8'hE6;
  localparam logic [7:0] RTCGS_SUPMODE_MASK = 8'h90;
  localparam logic [7:0] RTCGS_CTRL_MASK = 8'h87;

  // ----------------------------------------------------------------
  // divider and period constants
  // ----------------------------------------------------------------
  localparam logic [9:0] RTCGS_DIV_976 = 10'h3D0;
  localparam logic [9:0] RTCGS_DIV_488 = 10'h1E8;
  localparam logic [9:0] RTCGS_DIV_244 = 10'h0F4;
  localparam logic [15:0] RTCGS_TICKS_PER_SEC = 16'h8000;
  localparam logic [15:0] RTCGS_TICKS_HALF    = 16'h4000;
  localparam logic [2:0]  RTCGS_FIX_HALF      = 3'h1;
  localparam logic [2:0]  RTCGS_FIX_SEC       = 3'h2;

  // ----------------------------------------------------------------
  // count clock selection
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    RTCGS_SRC_SUB      = 3'b000,
    RTCGS_SRC_LOWSPEED = 3'b001,
    RTCGS_SRC_DIV976   = 3'b010,
    RTCGS_SRC_DIV488   = 3'b011,
    RTCGS_SRC_DIV244   = 3'b100,
    RTCGS_SRC_NONE     = 3'b111
  } rtcgs_src_e;

endpackage

// ==== core/rtcgs_sync.sv ====
// two flip-flop synchroniser for one level from outside the clock domain
`timescale 1ns/1ps
`default_nettype none
module rtcgs_sync (
  input  wire logic ref_clk_in,
  input  wire logic reset_n_in,
  input  wire logic async_in,
  output var  logic sync_out
);
  logic meta_q;

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      meta_q   <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule
`default_nettype wire

// ==== core/rtcgs_divider.sv ====
// main clock divider: one-cycle tick every div_in cycles while enabled
`timescale 1ns/1ps
`default_nettype none
module rtcgs_divider (
  input  wire logic       ref_clk_in,
  input  wire logic       reset_n_in,
  input  wire logic       enable_in,
  input  wire logic [9:0] div_in,
  output var  logic       tick_out
);
  logic [9:0] count_q;

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      count_q  <= 10'h000;
      tick_out <= 1'b0;
    end else if (!enable_in) begin
      count_q  <= 10'h000;
      tick_out <= 1'b0;
    end else if (count_q >= div_in - 10'h001) begin
      count_q  <= 10'h000;
      tick_out <= 1'b1;
    end else begin
      count_q  <= count_q + 10'h001;
      tick_out <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ==== core/rtcgs_top.sv ====
// calendar clock supply gate, count clock selector and register slave
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - control and count registers clear on power-on reset or while the gate is closed, not on other resets
// - seconds advance on divided main or subsystem clock; low-speed gives only fixed-cycle
// - with low-speed source, fixed interval scales by subsystem over low-speed frequency
// - gate bit 0 stops clock, holds calendar and interval timer reset, refuses control and count writes
// - gate bit 0 ignores control and count writes, reads reset values; selector excepted
// - select bit 7: 0 external high-speed clock, 1 internal high-speed oscillator
// - source field and divider bits pick subsystem, low-speed, main /976, /488, /244
// - low-power supply bit withholds subsystem clock from others during sleep
module rtcgs_top
  import rtcgs_pkg::*;
#(
  parameter logic [15:0] LOWSPEED_TICKS_PER_SEC = 16'h8000
) (
  input  wire logic       ref_clk_in,
  input  wire logic       reset_n_in,
  input  wire logic       por_n_in,
  input  wire logic       sys_reset_n_in,
  input  wire logic       sub_osc_tick_in,
  input  wire logic       lowspeed_osc_tick_in,
  input  wire logic       sleep_in,
  input  wire logic [7:0] addr_in,
  input  wire logic [7:0] wdata_in,
  input  wire logic       wr_in,
  input  wire logic       rd_in,
  output var  logic [7:0] rdata_out,
  output var  logic       irq_out,
  output var  logic       count_clock_gate_out,
  output var  logic       interval_timer_reset_out,
  output var  logic       main_source_select_out,
  output var  logic       sub_clock_to_periph_out
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
    return a == r;
  endfunction

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  logic sub_tick_s;
  logic ls_tick_s;
  logic sleep_s;
  logic por_n_s;
  logic sys_n_s;
  logic sub_tick_q;
  logic ls_tick_q;

  rtcgs_sync u_sync_sub (.ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in),
                         .async_in(sub_osc_tick_in), .sync_out(sub_tick_s));
  rtcgs_sync u_sync_ls (.ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in),
                        .async_in(lowspeed_osc_tick_in), .sync_out(ls_tick_s));
  rtcgs_sync u_sync_slp (.ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in),
                         .async_in(sleep_in), .sync_out(sleep_s));
  rtcgs_sync u_sync_por (.ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in),
                         .async_in(por_n_in), .sync_out(por_n_s));
  rtcgs_sync u_sync_sys (.ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in),
                         .async_in(sys_reset_n_in), .sync_out(sys_n_s));

  // edge detect on synchronised oscillator levels
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      sub_tick_q <= 1'b0;
      ls_tick_q  <= 1'b0;
    end else begin
      sub_tick_q <= sub_tick_s;
      ls_tick_q  <= ls_tick_s;
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [7:0] pce0_q;
  logic [7:0] sel_q;
  logic [7:0] supmode_q;
  logic [7:0] ctrl_q;
  logic [7:0] irq_st_q;
  logic [7:0] irq_msk_q;
  logic [15:0] sec_q;
  logic [15:0] frac_q;
  logic [15:0] fix_q;
  logic       gate;
  logic       por_clr;
  logic       wr_ok;
  rtcgs_src_e src;

  assign gate    = pce0_q[RTCGS_GATE_BIT];
  assign por_clr = !por_n_s;
  assign wr_ok   = wr_in && gate;

  // peripheral enable and clock selector: cleared by power-on reset only
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pce0_q    <= RTCGS_RST_BYTE;
      sel_q     <= RTCGS_RST_BYTE;
      supmode_q <= RTCGS_RST_BYTE;
    end else if (por_clr) begin
      pce0_q    <= RTCGS_RST_BYTE;
      sel_q     <= RTCGS_RST_BYTE;
      supmode_q <= RTCGS_RST_BYTE;
    end else if (wr_in) begin
      if (hit(addr_in, RTCGS_ADDR_PCE0)) pce0_q <= wdata_in;
      if (hit(addr_in, RTCGS_ADDR_SEL)) sel_q <= wdata_in & RTCGS_SEL_MASK;
      if (hit(addr_in, RTCGS_ADDR_SUPMODE)) supmode_q <= wdata_in & RTCGS_SUPMODE_MASK;
    end
  end

  // control register: held at reset value while the gate is closed
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ctrl_q <= RTCGS_RST_BYTE;
    end else if (por_clr || !gate) begin
      ctrl_q <= RTCGS_RST_BYTE;
    end else if (wr_ok && hit(addr_in, RTCGS_ADDR_CTRL)) begin
      ctrl_q <= wdata_in & RTCGS_CTRL_MASK;
    end
  end

  // ----------------------------------------------------------------
  // count clock selection and divider
  // ----------------------------------------------------------------
  always_comb begin
    case ({sel_q[RTCGS_SRC_HI_BIT], sel_q[RTCGS_SRC_LO_BIT],
           sel_q[RTCGS_DIV_HI_BIT], sel_q[RTCGS_DIV_LO_BIT]})
      4'b0000, 4'b0001, 4'b0010, 4'b0011: src = RTCGS_SRC_SUB;
      4'b0100, 4'b0101, 4'b0110, 4'b0111: src = RTCGS_SRC_LOWSPEED;
      4'b1010: src = RTCGS_SRC_DIV976;
      4'b1100: src = RTCGS_SRC_DIV488;
      4'b1110: src = RTCGS_SRC_DIV244;
      default: src = RTCGS_SRC_NONE;
    endcase
  end

  logic [9:0] div_val;
  logic       div_tick;
  always_comb begin
    case (src)
      RTCGS_SRC_DIV976: div_val = RTCGS_DIV_976;
      RTCGS_SRC_DIV488: div_val = RTCGS_DIV_488;
      default:          div_val = RTCGS_DIV_244;
    endcase
  end

  rtcgs_divider u_div (
    .ref_clk_in (ref_clk_in),
    .reset_n_in (reset_n_in),
    .enable_in  (gate && (src == RTCGS_SRC_DIV976 || src == RTCGS_SRC_DIV488 ||
                          src == RTCGS_SRC_DIV244)),
    .div_in     (div_val),
    .tick_out   (div_tick)
  );

  logic cnt_tick;
  always_comb begin
    case (src)
      RTCGS_SRC_SUB:      cnt_tick = sub_tick_s && !sub_tick_q;
      RTCGS_SRC_LOWSPEED: cnt_tick = ls_tick_s && !ls_tick_q;
      RTCGS_SRC_DIV976,
      RTCGS_SRC_DIV488,
      RTCGS_SRC_DIV244:   cnt_tick = div_tick;
      default:            cnt_tick = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // counters: seconds and fixed-cycle interval
  // ----------------------------------------------------------------
  logic run;
  logic calendar_ok;
  logic [15:0] per_sec;
  logic [15:0] fix_len;
  logic sec_evt;
  logic fix_evt;

  assign run         = gate && ctrl_q[RTCGS_RUN_BIT] && cnt_tick;
  assign calendar_ok = (src != RTCGS_SRC_LOWSPEED) && (src != RTCGS_SRC_NONE);
  // low-speed ticks per second stand in for subsystem ticks, scaling the interval
  assign per_sec = (src == RTCGS_SRC_LOWSPEED) ? LOWSPEED_TICKS_PER_SEC
                                               : RTCGS_TICKS_PER_SEC;
  assign fix_len = (ctrl_q[2:0] == RTCGS_FIX_HALF) ? {1'b0, per_sec[15:1]} : per_sec;
  assign sec_evt = run && calendar_ok && (frac_q == per_sec - 16'h0001);
  assign fix_evt = run && (ctrl_q[2:0] == RTCGS_FIX_HALF || ctrl_q[2:0] == RTCGS_FIX_SEC)
                   && (fix_q == fix_len - 16'h0001);

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      frac_q <= 16'h0000;
      sec_q  <= 16'h0000;
    end else if (por_clr || !gate) begin
      frac_q <= 16'h0000;
      sec_q  <= 16'h0000;
    end else if (wr_ok && hit(addr_in, RTCGS_ADDR_SECCNT)) begin
      sec_q  <= {8'h00, wdata_in};
    end else if (run && calendar_ok) begin
      frac_q <= sec_evt ? 16'h0000 : frac_q + 16'h0001;
      if (sec_evt) sec_q <= sec_q + 16'h0001;
    end
  end

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      fix_q <= 16'h0000;
    end else if (por_clr || !gate) begin
      fix_q <= 16'h0000;
    end else if (run) begin
      fix_q <= fix_evt ? 16'h0000 : fix_q + 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // interrupts: sticky status, write one to clear, set wins
  // ----------------------------------------------------------------
  logic [7:0] irq_set;
  always_comb begin
    irq_set = 8'h00;
    irq_set[RTCGS_IRQ_SEC_BIT] = sec_evt;
    irq_set[RTCGS_IRQ_FIX_BIT] = fix_evt;
  end

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      irq_st_q <= RTCGS_RST_BYTE;
    end else if (por_clr) begin
      irq_st_q <= RTCGS_RST_BYTE;
    end else begin
      irq_st_q <= (irq_st_q & ~((wr_in && hit(addr_in, RTCGS_ADDR_IRQ_ST)) ? wdata_in : 8'h00))
                  | irq_set;
    end
  end

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      irq_msk_q <= RTCGS_RST_BYTE;
    end else if (por_clr) begin
      irq_msk_q <= RTCGS_RST_BYTE;
    end else if (wr_in && hit(addr_in, RTCGS_ADDR_IRQ_MSK)) begin
      irq_msk_q <= wdata_in;
    end
  end

  // ----------------------------------------------------------------
  // read data and outputs
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rdata_out <= 8'h00;
    end else if (rd_in) begin
      case (addr_in)
        RTCGS_ADDR_PCE0:    rdata_out <= pce0_q;
        RTCGS_ADDR_SEL:     rdata_out <= sel_q;
        RTCGS_ADDR_SUPMODE: rdata_out <= supmode_q;
        RTCGS_ADDR_CTRL:    rdata_out <= ctrl_q;
        RTCGS_ADDR_SECCNT:  rdata_out <= sec_q[7:0];
        RTCGS_ADDR_FIXCNT:  rdata_out <= fix_q[7:0];
        RTCGS_ADDR_IRQ_ST:  rdata_out <= irq_st_q;
        RTCGS_ADDR_IRQ_MSK: rdata_out <= irq_msk_q;
        RTCGS_ADDR_STATUS:  rdata_out <= {4'h0, gate, src};
        default:            rdata_out <= 8'h00;
      endcase
    end else begin
      rdata_out <= 8'h00;
    end
  end

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      irq_out                  <= 1'b0;
      count_clock_gate_out     <= 1'b0;
      interval_timer_reset_out <= 1'b1;
      main_source_select_out   <= 1'b0;
      sub_clock_to_periph_out  <= 1'b1;
    end else begin
      irq_out                  <= |(irq_st_q & irq_msk_q);
      count_clock_gate_out     <= gate;
      interval_timer_reset_out <= !gate;
      main_source_select_out   <= sel_q[RTCGS_MAIN_SRC_BIT];
      sub_clock_to_periph_out  <= !(supmode_q[RTCGS_LPC_BIT] && sleep_s);
    end
  end

  // low-speed enable (supply mode bit 4) is software's duty before picking that source
  logic unused_ok;
  assign unused_ok = sys_n_s ^ supmode_q[RTCGS_LS_EN_BIT];

endmodule
`default_nettype wire

// ==== tb/rtcgs_checker.sv ====
// checker: port-level assertions for the calendar clock gate and selector
`timescale 1ns/1ps
`default_nettype none
module rtcgs_checker
  import rtcgs_pkg::*;
#(
  parameter logic [15:0] LOWSPEED_TICKS_PER_SEC = 16'h8000
) (
  input wire logic       ref_clk_in,
  input wire logic       reset_n_in,
  input wire logic       por_n_in,
  input wire logic       sys_reset_n_in,
  input wire logic       sub_osc_tick_in,
  input wire logic       lowspeed_osc_tick_in,
  input wire logic       sleep_in,
  input wire logic [7:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic       wr_in,
  input wire logic       rd_in,
  input wire logic [7:0] rdata_out,
  input wire logic       irq_out,
  input wire logic       count_clock_gate_out,
  input wire logic       interval_timer_reset_out,
  input wire logic       main_source_select_out,
  input wire logic       sub_clock_to_periph_out
);
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!reset_n_in);

  // ----------------------------------------------------------------
  // sequences
  // ----------------------------------------------------------------
  sequence gate_off_settled;
    !count_clock_gate_out && !(wr_in && addr_in == RTCGS_ADDR_PCE0);
  endsequence
  sequence ctrl_write_then_read;
    wr_in && addr_in == RTCGS_ADDR_CTRL && !count_clock_gate_out ##1 rd_in && addr_in == RTCGS_ADDR_CTRL;
  endsequence

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_gate_holds_timer: assert property (count_clock_gate_out != interval_timer_reset_out)
    else $error("timer reset does not mirror the gate");
  a_gate_write_lands: assert property (wr_in && addr_in == RTCGS_ADDR_PCE0 |->
    ##2 count_clock_gate_out == $past(wdata_in[RTCGS_GATE_BIT], 2))
    else $error("gate output does not follow the written bit");
  a_main_select_bit: assert property (wr_in && addr_in == RTCGS_ADDR_SEL |->
    ##2 main_source_select_out == $past(wdata_in[RTCGS_MAIN_SRC_BIT], 2))
    else $error("main source select does not follow bit 7");
  a_ctrl_write_refused: assert property (gate_off_settled ##1 ctrl_write_then_read |=> rdata_out == 8'h00)
    else $error("control write accepted while gated off");
  a_rdata_idle_zero: assert property (!rd_in |=> rdata_out == 8'h00)
    else $error("read data not zero outside a read");
  a_mask_clears_irq: assert property (wr_in && addr_in == RTCGS_ADDR_IRQ_MSK && wdata_in == 8'h00 |=> ##1 !irq_out)
    else $error("interrupt stays high with all masked");
  a_awake_sub_clock: assert property (!sleep_in [*4] |-> sub_clock_to_periph_out)
    else $error("subsystem clock withheld while awake");
  a_sys_reset_keeps: assert property ((!sys_reset_n_in && !wr_in && por_n_in) [*3] |->
    $stable(count_clock_gate_out) && $stable(main_source_select_out))
    else $error("other reset disturbed control registers");
endmodule

bind rtcgs_top rtcgs_checker #(.LOWSPEED_TICKS_PER_SEC(LOWSPEED_TICKS_PER_SEC)) rtcgs_checker_inst (
  .ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in), .por_n_in(por_n_in), .sys_reset_n_in(sys_reset_n_in),
  .sub_osc_tick_in(sub_osc_tick_in), .lowspeed_osc_tick_in(lowspeed_osc_tick_in), .sleep_in(sleep_in),
  .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
  .irq_out(irq_out), .count_clock_gate_out(count_clock_gate_out),
  .interval_timer_reset_out(interval_timer_reset_out), .main_source_select_out(main_source_select_out),
  .sub_clock_to_periph_out(sub_clock_to_periph_out)
);
`default_nettype wire

// ==== tb/testbench.sv ====
// self-checking bench for the calendar clock gate and selector
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import rtcgs_pkg::*;
  logic       ref_clk_in   = 1'b0;
  logic       reset_n_in   = 1'b0;
  logic       por_n_in     = 1'b1;
  logic       sys_reset_n_in = 1'b1;
  logic       sub_osc_tick_in = 1'b0;
  logic       ls_tick      = 1'b0;
  logic       sleep_in     = 1'b0;
  logic [7:0] addr_in      = 8'h00;
  logic [7:0] wdata_in     = 8'h00;
  logic       wr_in        = 1'b0;
  logic       rd_in        = 1'b0;
  logic [7:0] rdata_out;
  logic       irq_out;
  logic       gate;
  logic       timer_rst;
  logic       main_sel;
  logic       sub_clk;
  int         err_count    = 0;
  int         total_checks = 0;

  always #20 ref_clk_in = ~ref_clk_in;

  rtcgs_top #(.LOWSPEED_TICKS_PER_SEC(16'h0010)) rtcgs_top_inst (
    .ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in), .por_n_in(por_n_in), .sys_reset_n_in(sys_reset_n_in),
    .sub_osc_tick_in(sub_osc_tick_in), .lowspeed_osc_tick_in(ls_tick), .sleep_in(sleep_in),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .irq_out(irq_out), .count_clock_gate_out(gate), .interval_timer_reset_out(timer_rst),
    .main_source_select_out(main_sel), .sub_clock_to_periph_out(sub_clk));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic end_of_test;
    $display("checks=%0d errors=%0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // idle wait: lowers a write strobe left up by wr_reg
  task automatic cyc(input int n);
    wr_in <= 1'b0;
    repeat (n) @(posedge ref_clk_in);
  endtask
  // strobe stays up until the next read or idle wait lowers it
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    wr_in <= 1'b1;
    addr_in <= a;
    wdata_in <= d;
    @(posedge ref_clk_in);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    wr_in <= 1'b0;
    rd_in <= 1'b1;
    addr_in <= a;
    @(posedge ref_clk_in);
    rd_in <= 1'b0;
    @(negedge ref_clk_in);
    check(rdata_out, exp);
    @(posedge ref_clk_in);
  endtask
  task automatic osc_ticks(input logic use_sub, input int n);
    repeat (n) begin
      cyc(3);
      if (use_sub) sub_osc_tick_in <= 1'b1;
      else ls_tick <= 1'b1;
      cyc(3);
      sub_osc_tick_in <= 1'b0;
      ls_tick <= 1'b0;
    end
  endtask
  // outputs packed as {gate, timer reset, main select, sub clock, irq}
  task automatic out_chk(input logic [7:0] exp);
    check(8'({gate, timer_rst, main_sel, sub_clk, irq_out}), exp);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset_values;
    out_chk(8'h0A);
    rd_chk(RTCGS_ADDR_PCE0, 8'h00);
    rd_chk(RTCGS_ADDR_SEL, 8'h00);
    rd_chk(8'h30, 8'h00);
  endtask
  task automatic t_gate_off;
    wr_reg(RTCGS_ADDR_CTRL, 8'h87);
    rd_chk(RTCGS_ADDR_CTRL, 8'h00);
    wr_reg(RTCGS_ADDR_SECCNT, 8'h05);
    rd_chk(RTCGS_ADDR_SECCNT, 8'h00);
    wr_reg(RTCGS_ADDR_SEL, 8'h46);
    rd_chk(RTCGS_ADDR_SEL, 8'h46);
    wr_reg(RTCGS_ADDR_SEL, 8'h00);
  endtask
  task automatic t_gate_on;
    wr_reg(RTCGS_ADDR_PCE0, 8'h80);
    rd_chk(RTCGS_ADDR_PCE0, 8'h80);
    out_chk(8'h12);
    wr_reg(RTCGS_ADDR_CTRL, 8'hFF);
    rd_chk(RTCGS_ADDR_CTRL, 8'h87);
    wr_reg(RTCGS_ADDR_SECCNT, 8'h05);
    rd_chk(RTCGS_ADDR_SECCNT, 8'h05);
    wr_reg(RTCGS_ADDR_CTRL, 8'h00);
  endtask
  task automatic t_select;
    logic [7:0] sel_v [6] = '{8'h00, 8'h82, 8'h44, 8'h86, 8'h46, 8'hC4};
    rtcgs_src_e src_v [6] = '{RTCGS_SRC_SUB, RTCGS_SRC_LOWSPEED, RTCGS_SRC_DIV976,
                              RTCGS_SRC_DIV488, RTCGS_SRC_DIV244, RTCGS_SRC_DIV976};
    wr_reg(RTCGS_ADDR_SUPMODE, 8'h10);
    for (int i = 0; i < 6; i++) begin
      wr_reg(RTCGS_ADDR_SEL, sel_v[i]);
      rd_chk(RTCGS_ADDR_SEL, sel_v[i] & RTCGS_SEL_MASK);
      rd_chk(RTCGS_ADDR_STATUS, {4'h0, 1'b1, src_v[i]});
      check(8'(main_sel), 8'(sel_v[i][7]));
    end
  endtask
  // subsystem ticks, then main /244 ticks, advance the fixed counter
  task automatic t_count_clocks;
    wr_reg(RTCGS_ADDR_SEL, 8'h00);
    wr_reg(RTCGS_ADDR_CTRL, 8'h81);
    osc_ticks(1'b1, 3);
    rd_chk(RTCGS_ADDR_FIXCNT, 8'h03);
    wr_reg(RTCGS_ADDR_SEL, 8'h46);
    cyc(600);
    rd_chk(RTCGS_ADDR_FIXCNT, 8'h05);
    wr_reg(RTCGS_ADDR_PCE0, 8'h00);
    wr_reg(RTCGS_ADDR_PCE0, 8'h80);
    rd_chk(RTCGS_ADDR_FIXCNT, 8'h00);
    rd_chk(RTCGS_ADDR_CTRL, 8'h00);
  endtask
  task automatic t_lowspeed;
    wr_reg(RTCGS_ADDR_SUPMODE, 8'h10);
    wr_reg(RTCGS_ADDR_SEL, 8'h02);
    wr_reg(RTCGS_ADDR_SECCNT, 8'h00);
    wr_reg(RTCGS_ADDR_IRQ_MSK, 8'h02);
    wr_reg(RTCGS_ADDR_IRQ_ST, 8'h03);
    wr_reg(RTCGS_ADDR_CTRL, 8'h81);
    osc_ticks(1'b0, 7);
    rd_chk(RTCGS_ADDR_IRQ_ST, 8'h00);
    osc_ticks(1'b0, 1);
    cyc(4);
    rd_chk(RTCGS_ADDR_IRQ_ST, 8'h02);
    check(8'(irq_out), 8'h01);
    wr_reg(RTCGS_ADDR_IRQ_MSK, 8'h00);
    cyc(2);
    check(8'(irq_out), 8'h00);
    wr_reg(RTCGS_ADDR_IRQ_MSK, 8'h02);
    cyc(2);
    check(8'(irq_out), 8'h01);
    wr_reg(RTCGS_ADDR_IRQ_ST, 8'h02);
    cyc(2);
    check(8'(irq_out), 8'h00);
    rd_chk(RTCGS_ADDR_IRQ_ST, 8'h00);
    osc_ticks(1'b0, 16);
    rd_chk(RTCGS_ADDR_SECCNT, 8'h00);
    wr_reg(RTCGS_ADDR_IRQ_MSK, 8'h00);
  endtask
  task automatic t_sleep;
    sleep_in <= 1'b1;
    cyc(6);
    check(8'(sub_clk), 8'h01);
    wr_reg(RTCGS_ADDR_SUPMODE, 8'h90);
    cyc(3);
    check(8'(sub_clk), 8'h00);
    sleep_in <= 1'b0;
    cyc(6);
    check(8'(sub_clk), 8'h01);
  endtask
  task automatic t_resets;
    sys_reset_n_in <= 1'b0;
    cyc(6);
    rd_chk(RTCGS_ADDR_PCE0, 8'h80);
    rd_chk(RTCGS_ADDR_SEL, 8'h02);
    sys_reset_n_in <= 1'b1;
    cyc(4);
    por_n_in <= 1'b0;
    cyc(4);
    por_n_in <= 1'b1;
    cyc(6);
    rd_chk(RTCGS_ADDR_PCE0, 8'h00);
    rd_chk(RTCGS_ADDR_SEL, 8'h00);
    rd_chk(RTCGS_ADDR_SUPMODE, 8'h00);
    out_chk(8'h0A);
  endtask

  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    repeat (6) @(posedge ref_clk_in);
    reset_n_in <= 1'b1;
    cyc(2);
    t_reset_values;
    t_gate_off;
    t_gate_on;
    t_select;
    t_count_clocks;
    t_lowspeed;
    t_sleep;
    t_resets;
    end_of_test;
  end
  initial begin
    repeat (50000) @(posedge ref_clk_in);
    err_count++;
    end_of_test;
  end
endmodule
`default_nettype wire
